// [cell_balance_cfg.svh]
// Constants for the cell balance discharge controller: offsets, fields, resets, timing.
// Assumes a 200 MHz aclk; included by the package and the design module.
`ifndef CELL_BALANCE_CFG_SVH
`define CELL_BALANCE_CFG_SVH

`define ADDR_CONFIG_A 8'h00
`define ADDR_DISCHARGE_EN 8'h04
`define ADDR_CONFIG_B 8'h08
`define ADDR_PWM_0 8'h0C
`define ADDR_PWM_1 8'h10
`define ADDR_PWM_2 8'h14
`define ADDR_STATUS 8'h18
`define ADDR_UV_FLAGS 8'h1C
`define ADDR_OV_FLAGS 8'h20

`define CELLS 18
`define PWM_RESET 72'hFFFFFFFFFFFFFFFFFF
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`define CLK_PERIOD_NS 5
`define TICK_US 62500
`define TICK_CYCLES (`TICK_US * 1000 / `CLK_PERIOD_NS)
`define STEP_TICKS 32
`define PERIOD_TICKS 480
`define WDT_TICKS 32
`define HALF_MIN_TICKS 480

`endif

// [cell_balance_pkg.sv]
// Types for the cell balance discharge controller.
// Assumes an AXI4-Lite master with 8-bit byte addresses and 32-bit data.
`include "cell_balance_cfg.svh"
package cell_balance_pkg;
	typedef struct packed {
		logic awvalid;
		logic [7:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [7:0] araddr;
		logic rready;
	} axi_req_t;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} axi_rsp_t;

	typedef struct packed {
		axi_rsp_t rsp;
		logic aw_full;
		logic [7:0] aw_addr;
		logic w_full;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic [23:0] tick_cnt;
		logic tick;
		logic [8:0] phase;
		logic [5:0] wdt_cnt;
		logic [16:0] remain;
		logic [3:0] discharge_timeout_code;
		logic [17:0] dcc;
		logic mon_en;
		logic [71:0] pwm;
		logic [17:0] uv;
		logic [17:0] ov;
		logic drc_fail;
		logic conv_start;
		logic [17:0] sw;
	} state_t;
endpackage : cell_balance_pkg

// [cell_balance_discharge_control.sv]
// Discharge timer, staggered PWM balancing and timer monitor behind an AXI4-Lite slave.
// Assumes synchronous inputs and an external cell converter answering conv_start with conv_done.
`include "cell_balance_cfg.svh"
module cell_balance_discharge_control #(
	parameter int TICK_CYCLES = `TICK_CYCLES
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire cell_balance_pkg::axi_req_t axi_req,
	output cell_balance_pkg::axi_rsp_t axi_rsp,
	input wire logic discharge_timer_pin_enable,
	input wire logic sleep_entry,
	input wire logic conv_done,
	input wire logic [17:0] cell_uv,
	input wire logic [17:0] cell_ov,
	input wire logic conv_drc_fail,
	output logic conv_start,
	output logic [17:0] balance_switch
);
	cell_balance_pkg::state_t q;
	cell_balance_pkg::state_t d;

	// Timeout code to length in ticks, from a table in half minutes
	function automatic logic [16:0] code_ticks(input logic [3:0] c);
		logic [7:0] hm;
		hm = 8'h00;
		unique case (c)
			4'h0: hm = 8'h00;
			4'h1: hm = 8'h01;
			4'h2: hm = 8'h02;
			4'h3: hm = 8'h04;
			4'h4: hm = 8'h06;
			4'h5: hm = 8'h08;
			4'h6: hm = 8'h0A;
			4'h7: hm = 8'h14;
			4'h8: hm = 8'h1E;
			4'h9: hm = 8'h28;
			4'hA: hm = 8'h3C;
			4'hB: hm = 8'h50;
			4'hC: hm = 8'h78;
			4'hD: hm = 8'h96;
			4'hE: hm = 8'hB4;
			4'hF: hm = 8'hF0;
		endcase
		return 17'(hm * `HALF_MIN_TICKS);
	endfunction : code_ticks

	// Smallest bin whose upper edge covers the remaining time
	function automatic logic [3:0] remain_code(input logic [16:0] r);
		logic [3:0] c;
		c = 4'h0;
		if (r != 17'h00000) begin
			for (int k = 15; k >= 1; k--) begin
				if (r <= code_ticks(4'(k))) begin
					c = 4'(k);
				end
			end
		end
		return c;
	endfunction : remain_code

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[b*8 +: 8] = nw[b*8 +: 8];
			end
		end
		return r;
	endfunction : merge

	function automatic logic mapped(input logic [7:0] a);
		return a == `ADDR_CONFIG_A || a == `ADDR_DISCHARGE_EN || a == `ADDR_CONFIG_B || a == `ADDR_PWM_0
			|| a == `ADDR_PWM_1 || a == `ADDR_PWM_2 || a == `ADDR_STATUS || a == `ADDR_UV_FLAGS
			|| a == `ADDR_OV_FLAGS;
	endfunction : mapped

	// Position of channel ch inside the shared 30 s period, shifted by ch stagger ticks
	function automatic logic pwm_on(input logic [8:0] phase, input int ch, input logic [3:0] code);
		logic [9:0] local_ph;
		logic [3:0] step;
		local_ph = 10'(phase) + 10'(`PERIOD_TICKS) - 10'(ch);
		if (local_ph >= 10'(`PERIOD_TICKS)) begin
			local_ph = local_ph - 10'(`PERIOD_TICKS);
		end
		step = 4'(local_ph / 10'(`STEP_TICKS));
		return step < code || code == 4'hF;
	endfunction : pwm_on

	logic wdt_expired;
	logic timer_active;
	logic do_write;
	logic expire;
	assign wdt_expired = q.wdt_cnt > 6'(`WDT_TICKS);
	assign timer_active = discharge_timer_pin_enable && q.remain != 17'h00000;
	assign do_write = q.aw_full && q.w_full && !q.rsp.bvalid;
	assign expire = timer_active && q.tick && q.remain == 17'h00001;

	always_comb begin
		logic [31:0] wv;
		logic [71:0] pwm_w;
		wv = 32'h00000000;
		pwm_w = q.pwm;
		d = q;
		d.conv_start = 1'b0;
		// Shared slow timebase: one tick per 62.5 ms
		d.tick = 1'b0;
		if (q.tick_cnt == 24'(TICK_CYCLES - 1)) begin
			d.tick_cnt = 24'h000000;
			d.tick = 1'b1;
		end else begin
			d.tick_cnt = q.tick_cnt + 24'h000001;
		end
		if (q.tick) begin
			d.phase = (q.phase == 9'(`PERIOD_TICKS - 1)) ? 9'h000 : q.phase + 9'h001;
			if (!wdt_expired) begin
				d.wdt_cnt = q.wdt_cnt + 6'h01;
			end
			if (timer_active) begin
				d.remain = q.remain - 17'h00001;
			end
		end
		// Watchdog expiry with no running timer clears the discharge setup
		if (q.tick && q.wdt_cnt == 6'(`WDT_TICKS) && !timer_active) begin
			d.discharge_timeout_code = 4'h0;
			d.dcc = 18'h00000;
			d.mon_en = 1'b0;
		end
		if (expire) begin
			d.discharge_timeout_code = 4'h0;
			d.dcc = 18'h00000;
			d.mon_en = 1'b0;
		end
		// Periodic monitor conversion
		if (q.mon_en && wdt_expired && timer_active && q.tick && q.phase == 9'h000) begin
			d.conv_start = 1'b1;
		end
		if (conv_done) begin
			d.uv = cell_uv;
			d.ov = cell_ov;
			d.drc_fail = conv_drc_fail;
			if (conv_drc_fail) begin
				d.dcc = 18'h00000;
			end else begin
				d.dcc = d.dcc & ~cell_uv;
			end
		end
		if (sleep_entry) begin
			d.pwm = `PWM_RESET;
		end
		// Write channels, taken in either order
		if (axi_req.awvalid && q.rsp.awready) begin
			d.aw_full = 1'b1;
			d.aw_addr = axi_req.awaddr;
		end
		if (axi_req.wvalid && q.rsp.wready) begin
			d.w_full = 1'b1;
			d.w_data = axi_req.wdata;
			d.w_strb = axi_req.wstrb;
		end
		if (q.rsp.bvalid && axi_req.bready) begin
			d.rsp.bvalid = 1'b0;
		end
		if (do_write) begin
			d.aw_full = 1'b0;
			d.w_full = 1'b0;
			d.rsp.bvalid = 1'b1;
			d.rsp.bresp = mapped(q.aw_addr) ? `RESP_OKAY : `RESP_SLVERR;
			d.wdt_cnt = 6'h00;
			unique case (q.aw_addr)
				`ADDR_CONFIG_A: begin
					wv = merge({28'h0000000, q.discharge_timeout_code}, q.w_data, q.w_strb);
					d.discharge_timeout_code = wv[3:0];
					d.remain = code_ticks(wv[3:0]);
				end
				`ADDR_DISCHARGE_EN: begin
					wv = merge({14'h0000, q.dcc}, q.w_data, q.w_strb);
					d.dcc = wv[17:0];
				end
				`ADDR_CONFIG_B: begin
					wv = merge({31'h00000000, q.mon_en}, q.w_data, q.w_strb);
					d.mon_en = wv[0];
				end
				`ADDR_PWM_0: begin
					pwm_w[31:0] = merge(q.pwm[31:0], q.w_data, q.w_strb);
				end
				`ADDR_PWM_1: begin
					pwm_w[63:32] = merge(q.pwm[63:32], q.w_data, q.w_strb);
				end
				`ADDR_PWM_2: begin
					wv = merge({24'h000000, q.pwm[71:64]}, q.w_data, q.w_strb);
					pwm_w[71:64] = wv[7:0];
				end
				default: begin
					wv = 32'h00000000;
				end
			endcase
			if (!sleep_entry) begin
				d.pwm = pwm_w;
			end
		end
		d.rsp.awready = !d.aw_full;
		d.rsp.wready = !d.w_full;
		// Read channel
		if (q.rsp.rvalid && axi_req.rready) begin
			d.rsp.rvalid = 1'b0;
		end
		if (axi_req.arvalid && q.rsp.arready) begin
			d.rsp.rvalid = 1'b1;
			d.rsp.rresp = mapped(axi_req.araddr) ? `RESP_OKAY : `RESP_SLVERR;
			unique case (axi_req.araddr)
				`ADDR_CONFIG_A: d.rsp.rdata = {28'h0000000, remain_code(timer_active ? q.remain : 17'h00000)};
				`ADDR_DISCHARGE_EN: d.rsp.rdata = {14'h0000, q.dcc};
				`ADDR_CONFIG_B: d.rsp.rdata = {31'h00000000, q.mon_en};
				`ADDR_PWM_0: d.rsp.rdata = q.pwm[31:0];
				`ADDR_PWM_1: d.rsp.rdata = q.pwm[63:32];
				`ADDR_PWM_2: d.rsp.rdata = {24'h000000, q.pwm[71:64]};
				`ADDR_STATUS: d.rsp.rdata = {29'h00000000, q.drc_fail, timer_active, wdt_expired};
				`ADDR_UV_FLAGS: d.rsp.rdata = {14'h0000, q.uv};
				`ADDR_OV_FLAGS: d.rsp.rdata = {14'h0000, q.ov};
				default: d.rsp.rdata = 32'h00000000;
			endcase
		end
		d.rsp.arready = !d.rsp.rvalid;
		// Balance outputs
		for (int ch = 0; ch < `CELLS; ch++) begin
			if (!wdt_expired) begin
				d.sw[ch] = q.dcc[ch];
			end else begin
				d.sw[ch] = timer_active && q.dcc[ch] && pwm_on(q.phase, ch, q.pwm[ch*4 +: 4]);
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= '0;
			q.rsp.awready <= 1'b1;
			q.rsp.wready <= 1'b1;
			q.rsp.arready <= 1'b1;
			q.pwm <= `PWM_RESET;
		end else begin
			q <= d;
		end
	end

	assign axi_rsp = q.rsp;
	assign conv_start = q.conv_start;
	assign balance_switch = q.sw;

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	sequence s_cfga_write;
		do_write && q.aw_addr == `ADDR_CONFIG_A && q.w_strb[0];
	endsequence

	sequence s_other_write;
		do_write && q.aw_addr != `ADDR_CONFIG_A;
	endsequence

	chk_direct_follow: assert property (!$past(wdt_expired) |-> balance_switch == $past(q.dcc))
		else $error("balance output differs from enable bit before watchdog expiry");

	chk_disabled_off: assert property ((balance_switch & ~$past(q.dcc)) == 18'h00000)
		else $error("balance output on for a disabled channel");

	chk_sleep_default: assert property (sleep_entry |=> q.pwm == `PWM_RESET)
		else $error("duty codes not restored on sleep entry");

	chk_timer_restart: assert property (s_cfga_write |=> q.remain == code_ticks(q.discharge_timeout_code))
		else $error("discharge timer not restarted by group A write");

	chk_timer_no_restart: assert property (s_other_write |=> q.remain <= $past(q.remain))
		else $error("discharge timer restarted by another command");

	chk_uv_clears: assert property (conv_done && !conv_drc_fail && !do_write |=> (q.dcc & $past(cell_uv)) == 18'h00000)
		else $error("undervoltage cell still enabled");

	chk_drc_clears: assert property (conv_done && conv_drc_fail && !do_write |=> q.dcc == 18'h00000)
		else $error("redundancy failure left enable bits set");

	chk_wdt_expiry: assert property (q.wdt_cnt <= 6'(`WDT_TICKS + 1))
		else $error("watchdog count out of range");

	chk_code_zero: assert property (q.rsp.rvalid && $rose(q.rsp.rvalid) && $past(axi_req.araddr) == `ADDR_CONFIG_A
		&& $past(timer_active) |-> q.rsp.rdata[3:0] != 4'h0)
		else $error("running timer read back as zero code");

	chk_phase_step: assert property (q.tick |=> q.phase == ($past(q.phase) == 9'(`PERIOD_TICKS - 1) ? 9'h000
		: $past(q.phase) + 9'h001))
		else $error("PWM phase did not advance on tick");

	chk_expiry_reset: assert property (expire && !do_write && !conv_done |=> q.dcc == 18'h00000 && q.discharge_timeout_code == 4'h0)
		else $error("timer expiry did not reset switch control");
endmodule : cell_balance_discharge_control

// [cell_converter_model.sv]
// Stand-in for the cell converter behind the balance controller.
// Assumes the bench sets the flags that each conversion is to report.
module cell_converter_model (
	input wire logic aclk,
	input wire logic conv_start,
	input wire logic [17:0] uv_set,
	input wire logic drc_set,
	output logic conv_done,
	output logic [17:0] cell_uv,
	output logic [17:0] cell_ov,
	output logic conv_drc_fail,
	output int starts
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		conv_done = 1'b0;
		cell_uv = 18'h0;
		cell_ov = 18'h0;
		conv_drc_fail = 1'b0;
		starts = 0;
	end
	always @(posedge aclk) begin
		if (conv_start) begin
			starts <= starts + 1;
			repeat (3) @(posedge aclk);
			conv_done <= 1'b1;
			cell_uv <= uv_set;
			cell_ov <= 18'h0;
			conv_drc_fail <= drc_set;
			@(posedge aclk);
			conv_done <= 1'b0;
			// Results are not valid outside the done pulse
			cell_uv <= ~uv_set;
			cell_ov <= 18'h3FFFF;
			conv_drc_fail <= ~drc_set;
		end
	end
endmodule : cell_converter_model

// [cell_balance_discharge_control_bench.sv]
// Self-checking bench for the cell balance discharge controller.
// Assumes a shortened timebase of four clocks per tick.
module cell_balance_discharge_control_bench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int TICK = 4;
	logic aclk;
	logic aresetn;
	cell_balance_pkg::axi_req_t rq;
	cell_balance_pkg::axi_rsp_t rs;
	logic pin_en, sleep_entry, conv_start, conv_done, drc_fail, drc_set;
	logic [17:0] cell_uv, cell_ov, sw, uv_set, prev;
	logic [31:0] rd_q;
	logic [1:0] resp;
	int n_errors, cmp_count, starts, s0, cyc;
	int on_cnt [5];
	int rise [5];
	int exp_on [5] = '{0, 480 * TICK, 32 * TICK, 0, 32 * TICK};

	cell_balance_discharge_control #(.TICK_CYCLES(TICK)) dut (.aclk(aclk), .aresetn(aresetn),
		.axi_req(rq), .axi_rsp(rs), .discharge_timer_pin_enable(pin_en), .sleep_entry(sleep_entry),
		.conv_done(conv_done), .cell_uv(cell_uv), .cell_ov(cell_ov), .conv_drc_fail(drc_fail),
		.conv_start(conv_start), .balance_switch(sw));
	cell_converter_model conv (.aclk(aclk), .conv_start(conv_start), .uv_set(uv_set), .drc_set(drc_set),
		.conv_done(conv_done), .cell_uv(cell_uv), .cell_ov(cell_ov), .conv_drc_fail(drc_fail),
		.starts(starts));

	initial begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end

	task check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask : check

	task conclude;
		$display("mismatches %0d compares %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : conclude

	// Handshakes are judged at the rising edge, released right after it
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic b;
		rq.awvalid <= 1'b1;
		rq.awaddr <= a;
		rq.wvalid <= 1'b1;
		rq.wdata <= d;
		b = 1'b0;
		while (!b) begin
			@(posedge aclk);
			if (rq.awvalid && rs.awready) rq.awvalid <= 1'b0;
			if (rq.wvalid && rs.wready) rq.wvalid <= 1'b0;
			b = rs.bvalid;
			resp = rs.bresp;
		end
	endtask : wr

	task rdc(input logic [7:0] a, input logic [31:0] exp);
		logic r;
		rq.arvalid <= 1'b1;
		rq.araddr <= a;
		r = 1'b0;
		while (!r) begin
			@(posedge aclk);
			if (rq.arvalid && rs.arready) rq.arvalid <= 1'b0;
			r = rs.rvalid;
			rd_q = rs.rdata;
			resp = rs.rresp;
		end
		check(rd_q, exp);
	endtask : rdc

	task idle(input int n);
		repeat (n) @(posedge aclk);
	endtask : idle

	always @(posedge aclk) begin
		cyc++;
		if (cyc == 30000) begin
			n_errors++;
			conclude;
		end
	end

	initial begin
		rq = '0;
		rq.wstrb = 4'hF;
		rq.bready = 1'b1;
		rq.rready = 1'b1;
		aresetn = 1'b0;
		pin_en = 1'b1;
		sleep_entry = 1'b0;
		uv_set = 18'h0;
		drc_set = 1'b0;
		idle(16);
		aresetn <= 1'b1;
		rdc(8'h0C, 32'hFFFFFFFF);
		rdc(8'h14, 32'h000000FF);
		rdc(8'h40, 32'h0);
		check({30'h0, resp}, 32'h2);
		wr(8'h04, 32'h15);
		idle(2);
		check({14'h0, sw}, 32'h15);
		for (int c = 1; c < 16; c++) begin
			wr(8'h00, 32'(c));
			rdc(8'h00, 32'(c));
		end
		pin_en <= 1'b0;
		rdc(8'h00, 32'h0);
		pin_en <= 1'b1;
		wr(8'h00, 32'h2);
		rdc(8'h18, 32'h2);
		idle(485 * TICK);
		wr(8'h04, 32'h15);
		rdc(8'h00, 32'h1);
		wr(8'h00, 32'h2);
		rdc(8'h00, 32'h2);
		wr(8'h00, 32'h1);
		idle(490 * TICK);
		rdc(8'h00, 32'h0);
		rdc(8'h04, 32'h0);
		rdc(8'h18, 32'h1);
		// Staggered duty codes 0, 15, 1, 15, 1 with channel 3 left disabled
		wr(8'h08, 32'h1);
		wr(8'h0C, 32'hFFF1F1F0);
		wr(8'h04, 32'h17);
		wr(8'h00, 32'h4);
		idle(34 * TICK);
		rdc(8'h18, 32'h3);
		on_cnt = '{0, 0, 0, 0, 0};
		rise = '{0, 0, 0, 0, 0};
		prev = sw;
		s0 = starts;
		for (int i = 0; i < 480 * TICK; i++) begin
			@(negedge aclk);
			for (int k = 0; k < 5; k++) begin
				if (sw[k] === 1'b1) on_cnt[k]++;
				if (sw[k] === 1'b1 && prev[k] === 1'b0) rise[k] = i;
			end
			prev = sw;
		end
		for (int k = 0; k < 5; k++)
			check(32'(on_cnt[k]), 32'(exp_on[k]));
		check(32'((rise[4] - rise[2] + 480 * TICK) % (480 * TICK)), 32'(2 * TICK));
		check(32'(starts - s0), 32'h1);
		uv_set <= 18'h4;
		idle(490 * TICK);
		rdc(8'h04, 32'h13);
		rdc(8'h1C, 32'h4);
		drc_set <= 1'b1;
		idle(490 * TICK);
		rdc(8'h04, 32'h0);
		wr(8'h10, 32'h0);
		rdc(8'h10, 32'h0);
		sleep_entry <= 1'b1;
		idle(1);
		sleep_entry <= 1'b0;
		rdc(8'h10, 32'hFFFFFFFF);
		conclude;
	end
endmodule : cell_balance_discharge_control_bench
